/* core/smr_pkg.sv */
package smr_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_NS = 40;
  localparam int SLOW_HZ = 125_000;
  localparam int SETTLE_NS_DEF = 100_000;
  localparam int FILT_SAMPLES = 4;
  localparam logic [5:0] RST_TICKS = 6'h20;
  localparam logic [9:0] IDX_PM0 = 10'h004;
  localparam logic [9:0] IDX_PM1 = 10'h005;
  localparam logic [9:0] IDX_CM1 = 10'h007;
  localparam logic [9:0] IDX_DETECT_LEVEL_STATUS = 10'h031;
  localparam logic [9:0] IDX_DETECT_CIRCUIT_CONTROL = 10'h032;
  localparam logic [9:0] IDX_SUPPLY_MONITOR_ONE_CONTROL = 10'h036;
  localparam logic [9:0] IDX_SUPPLY_MONITOR_TWO_CONTROL = 10'h037;
  localparam int B_SOFT = 3;
  localparam int B_WDT_SEL = 2;
  localparam int B_OSC_STOP = 4;
  localparam int B_LEVEL2 = 3;
  localparam int B_DET1 = 6;
  localparam int B_DET2 = 7;
  localparam int B_EN = 0;
  localparam int B_FDIS = 1;
  localparam int B_FLAG = 2;
  localparam int B_WDTF = 3;
  localparam int B_DIV_LO = 4;
  localparam int B_DIV_HI = 5;
  localparam int B_MODE = 6;
  localparam int B_COND = 7;
  localparam logic [7:0] SUPPLY_MONITOR_ONE_CONTROL_HW = 8'h00;
  localparam logic [7:0] SUPPLY_MONITOR_ONE_CONTROL_POR = 8'h41;
  localparam logic [7:0] SUPPLY_MONITOR_ONE_CONTROL_WMASK = 8'hF7;
  localparam logic [7:0] SUPPLY_MONITOR_TWO_CONTROL_RST = 8'h00;
  localparam logic [7:0] SUPPLY_MONITOR_TWO_CONTROL_FLAGS = 8'h0C;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_RESTART = 3'b100
  } smr_state_t;
endpackage : smr_pkg

/* core/smr_filter.sv */
module smr_filter #(
  parameter int SAMPLES = smr_pkg::FILT_SAMPLES
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [1:0] div_sel,
  input wire logic bypass,
  input wire logic raw,
  output logic level
);
  logic [2:0] div_cnt_reg;
  logic [SAMPLES-1:0] hist_reg;
  logic level_reg;
  logic sample_en;

  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'b00: div_mask = 3'h0;
      2'b01: div_mask = 3'h1;
      2'b10: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction : div_mask

  // Prescaler runs free so a divider change needs no resync
  assign sample_en = tick && ((div_cnt_reg & div_mask(div_sel)) == 3'h0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt_reg <= 3'h0;
    end else if (tick) begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hist_reg <= '0;
    end else if (sample_en) begin
      hist_reg <= {hist_reg[SAMPLES-2:0], raw};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_reg <= 1'b0;
    end else if (bypass) begin
      level_reg <= raw;
    end else if (&hist_reg) begin
      level_reg <= 1'b1;
    end else if (~|hist_reg) begin
      level_reg <= 1'b0;
    end
  end

  assign level = level_reg;
endmodule : smr_filter

/* core/smr_top.sv */
module smr_top #(
  parameter int SETTLE_NS = smr_pkg::SETTLE_NS_DEF,
  parameter int SLOW_DIV = smr_pkg::CLK_HZ / smr_pkg::SLOW_HZ
)(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CMP1_BELOW,
  input wire logic CMP2_BELOW,
  input wire logic POWER_ON_DET,
  input wire logic WDT_UNDERFLOW,
  output logic DET1_ENABLE,
  output logic DET2_ENABLE,
  output logic SLOW_OSC_RUN,
  output logic SYS_RESET,
  output logic SFR_RESET,
  output logic CPU_RESTART,
  output logic CPU_CLK_DIV8,
  output logic MON2_IRQ,
  output logic WDT_IRQ
);
  localparam int SETTLE_CYC =
    (SETTLE_NS + smr_pkg::CLK_NS - 1) / smr_pkg::CLK_NS;

  smr_pkg::smr_state_t state_reg;
  logic [15:0] osc_cnt_reg;
  logic [15:0] settle_cnt_reg;
  logic [5:0] hold_cnt_reg;
  logic [2:0] pin_s1, pin_s2, pin_s3, pin_lvl;
  logic [1:0] filt_lvl;
  logic [7:0] supply_monitor_one_control_reg, supply_monitor_two_control_reg, supply_monitor_two_control_next, rd_byte;
  logic watchdog_action_select_reg, osc_stop_reg, det1_reg, det2_reg;
  logic prev2_reg, hold_m1_reg, hold_por_reg;
  logic sys_rst_reg, sfr_rst_reg, restart_reg, irq2_reg, wdt_irq_reg;
  logic [31:0] prdata_reg;
  logic osc_tick, acc, wr, mapped, settled, level2;
  logic soft_req, wdt_req, m1_req, m2_req, por_req, fire, cold;
  logic rise2, fall2, pass2, cross_evt, m2_evt, hold_done;

  function automatic logic hit(input logic [11:0] a,
                               input logic [9:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  // Slow oscillator as an enable; frozen by its stop bit
  assign osc_tick = !osc_stop_reg &&
                    (osc_cnt_reg == 16'(SLOW_DIV - 1));

  always_ff @(posedge CLK) begin
    if (!RESET_N || osc_tick) begin
      osc_cnt_reg <= 16'h0000;
    end else if (!osc_stop_reg) begin
      osc_cnt_reg <= osc_cnt_reg + 16'h0001;
    end
  end

  // Analog pins: three stages, accept once stages two and three agree
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
      pin_lvl <= 3'h0;
    end else begin
      pin_s1 <= {POWER_ON_DET, CMP2_BELOW, CMP1_BELOW};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_lvl <= (pin_s2 & ~(pin_s2 ^ pin_s3)) |
                 (pin_lvl & (pin_s2 ^ pin_s3));
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic [7:0] ctl;
    assign ctl = (i == 0) ? supply_monitor_one_control_reg : supply_monitor_two_control_reg;
    smr_filter u_filt (
      .clk(CLK),
      .rst_n(RESET_N),
      .tick(osc_tick),
      .div_sel(ctl[smr_pkg::B_DIV_HI:smr_pkg::B_DIV_LO]),
      .bypass(ctl[smr_pkg::B_FDIS]),
      .raw(pin_lvl[i]),
      .level(filt_lvl[i])
    );
  end

  // Detector 2 settle timer; restarts whenever the circuit is off
  always_ff @(posedge CLK) begin
    if (!RESET_N || !det2_reg) begin
      settle_cnt_reg <= 16'h0000;
    end else if (!settled) begin
      settle_cnt_reg <= settle_cnt_reg + 16'h0001;
    end
  end
  assign settled = (settle_cnt_reg == 16'(SETTLE_CYC));
  assign level2 = det2_reg && settled && !filt_lvl[1];

  // Channel 2 crossings
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      prev2_reg <= 1'b0;
    end else begin
      prev2_reg <= filt_lvl[1];
    end
  end
  assign rise2 = prev2_reg && !filt_lvl[1];
  assign fall2 = !prev2_reg && filt_lvl[1];
  assign pass2 = !supply_monitor_two_control_reg[smr_pkg::B_FDIS] ? (rise2 || fall2) :
                 (supply_monitor_two_control_reg[smr_pkg::B_COND] ? fall2 : rise2);
  assign cross_evt = det2_reg && pass2;
  assign m2_evt = cross_evt && supply_monitor_two_control_reg[smr_pkg::B_EN];

  // Reset sources; only one reset sequence runs at a time
  assign acc = PSEL && PENABLE;
  assign wr = acc && PWRITE && (state_reg == smr_pkg::ST_IDLE);
  assign soft_req = wr && hit(PADDR, smr_pkg::IDX_PM0) &&
                    PWDATA[smr_pkg::B_SOFT];
  assign wdt_req = WDT_UNDERFLOW && watchdog_action_select_reg;
  assign m1_req = det1_reg && supply_monitor_one_control_reg[smr_pkg::B_EN] && filt_lvl[0];
  assign m2_req = m2_evt && supply_monitor_two_control_reg[smr_pkg::B_MODE];
  assign por_req = pin_lvl[2];
  assign fire = (state_reg == smr_pkg::ST_IDLE) &&
                (soft_req || wdt_req || m1_req || m2_req || por_req);
  assign cold = fire && (por_req || m1_req);
  assign hold_done = (hold_cnt_reg == smr_pkg::RST_TICKS);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_reg <= smr_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        smr_pkg::ST_IDLE: begin
          if (fire) begin
            state_reg <= smr_pkg::ST_HOLD;
          end
        end
        smr_pkg::ST_HOLD: begin
          if (hold_done) begin
            state_reg <= smr_pkg::ST_RESTART;
          end
        end
        smr_pkg::ST_RESTART: state_reg <= smr_pkg::ST_IDLE;
        default: state_reg <= smr_pkg::ST_IDLE;
      endcase
    end
  end

  // Monitor-1 and power-on causes hold the count at zero until the supply recovers
  always_ff @(posedge CLK) begin
    if (!RESET_N || fire) begin
      hold_cnt_reg <= 6'h00;
    end else if (state_reg == smr_pkg::ST_HOLD) begin
      if ((hold_m1_reg && filt_lvl[0]) || (hold_por_reg && por_req)) begin
        hold_cnt_reg <= 6'h00;
      end else if (osc_tick && !hold_done) begin
        hold_cnt_reg <= hold_cnt_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      hold_m1_reg <= 1'b0;
      hold_por_reg <= 1'b0;
    end else if (fire) begin
      hold_m1_reg <= m1_req;
      hold_por_reg <= por_req;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sys_rst_reg <= 1'b0;
      restart_reg <= 1'b0;
      sfr_rst_reg <= 1'b0;
    end else begin
      sfr_rst_reg <= fire;
      restart_reg <= (state_reg == smr_pkg::ST_HOLD) && hold_done;
      if (fire) begin
        sys_rst_reg <= 1'b1;
      end else if (hold_done) begin
        sys_rst_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      irq2_reg <= 1'b0;
      wdt_irq_reg <= 1'b0;
    end else begin
      irq2_reg <= m2_evt && !supply_monitor_two_control_reg[smr_pkg::B_MODE];
      wdt_irq_reg <= WDT_UNDERFLOW && !watchdog_action_select_reg;
    end
  end

  // Monitor-1 control: cold value after power-on or own reset
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      supply_monitor_one_control_reg <= smr_pkg::SUPPLY_MONITOR_ONE_CONTROL_HW;
    end else if (cold) begin
      supply_monitor_one_control_reg <= smr_pkg::SUPPLY_MONITOR_ONE_CONTROL_POR;
    end else if (wr && hit(PADDR, smr_pkg::IDX_SUPPLY_MONITOR_ONE_CONTROL)) begin
      supply_monitor_one_control_reg <= PWDATA[7:0] & smr_pkg::SUPPLY_MONITOR_ONE_CONTROL_WMASK;
    end
  end

  // Flags: a write of one keeps, zero clears, a new event wins
  always_comb begin
    supply_monitor_two_control_next = supply_monitor_two_control_reg;
    if (cold) begin
      supply_monitor_two_control_next = smr_pkg::SUPPLY_MONITOR_TWO_CONTROL_RST;
    end else if (fire) begin
      supply_monitor_two_control_next = supply_monitor_two_control_reg & smr_pkg::SUPPLY_MONITOR_TWO_CONTROL_FLAGS;
    end else if (wr && hit(PADDR, smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL)) begin
      supply_monitor_two_control_next = (PWDATA[7:0] & ~smr_pkg::SUPPLY_MONITOR_TWO_CONTROL_FLAGS) |
                  (supply_monitor_two_control_reg & PWDATA[7:0] & smr_pkg::SUPPLY_MONITOR_TWO_CONTROL_FLAGS);
    end
    if (cross_evt) begin
      supply_monitor_two_control_next[smr_pkg::B_FLAG] = 1'b1;
    end
    if (WDT_UNDERFLOW) begin
      supply_monitor_two_control_next[smr_pkg::B_WDTF] = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      supply_monitor_two_control_reg <= smr_pkg::SUPPLY_MONITOR_TWO_CONTROL_RST;
    end else begin
      supply_monitor_two_control_reg <= supply_monitor_two_control_next;
    end
  end

  // Detector enables follow monitor-1 retention
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      det1_reg <= 1'b0;
      det2_reg <= 1'b0;
    end else if (cold) begin
      det1_reg <= 1'b1;
      det2_reg <= 1'b0;
    end else if (wr && hit(PADDR, smr_pkg::IDX_DETECT_CIRCUIT_CONTROL)) begin
      det1_reg <= PWDATA[smr_pkg::B_DET1];
      det2_reg <= PWDATA[smr_pkg::B_DET2];
    end
  end

  // Ordinary registers clear on every reset; the divide-by-8 CPU
  // clock default is pulsed out with the restart
  always_ff @(posedge CLK) begin
    if (!RESET_N || fire) begin
      watchdog_action_select_reg <= 1'b0;
      osc_stop_reg <= 1'b0;
    end else if (wr && hit(PADDR, smr_pkg::IDX_PM1)) begin
      watchdog_action_select_reg <= PWDATA[smr_pkg::B_WDT_SEL];
    end else if (wr && hit(PADDR, smr_pkg::IDX_CM1)) begin
      osc_stop_reg <= PWDATA[smr_pkg::B_OSC_STOP];
    end
  end

  // APB read side; soft reset bit is never stored
  always_comb begin
    rd_byte = 8'h00;
    mapped = 1'b1;
    if (hit(PADDR, smr_pkg::IDX_PM0)) begin
      rd_byte = 8'h00;
    end else if (hit(PADDR, smr_pkg::IDX_PM1)) begin
      rd_byte[smr_pkg::B_WDT_SEL] = watchdog_action_select_reg;
    end else if (hit(PADDR, smr_pkg::IDX_CM1)) begin
      rd_byte[smr_pkg::B_OSC_STOP] = osc_stop_reg;
    end else if (hit(PADDR, smr_pkg::IDX_DETECT_LEVEL_STATUS)) begin
      rd_byte[smr_pkg::B_LEVEL2] = level2;
    end else if (hit(PADDR, smr_pkg::IDX_DETECT_CIRCUIT_CONTROL)) begin
      rd_byte[smr_pkg::B_DET1] = det1_reg;
      rd_byte[smr_pkg::B_DET2] = det2_reg;
    end else if (hit(PADDR, smr_pkg::IDX_SUPPLY_MONITOR_ONE_CONTROL)) begin
      rd_byte = supply_monitor_one_control_reg;
    end else if (hit(PADDR, smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL)) begin
      rd_byte = supply_monitor_two_control_reg;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      prdata_reg <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !mapped;
  assign DET1_ENABLE = det1_reg;
  assign DET2_ENABLE = det2_reg;
  assign SLOW_OSC_RUN = !osc_stop_reg;
  assign SYS_RESET = sys_rst_reg;
  assign SFR_RESET = sfr_rst_reg;
  assign CPU_RESTART = restart_reg;
  assign CPU_CLK_DIV8 = restart_reg;
  assign MON2_IRQ = irq2_reg;
  assign WDT_IRQ = wdt_irq_reg;

  property p_soft;
    @(posedge CLK) disable iff (!RESET_N) soft_req |=> SYS_RESET;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset missed");

  property p_wdt;
    @(posedge CLK) disable iff (!RESET_N)
      (WDT_UNDERFLOW && watchdog_action_select_reg && state_reg == smr_pkg::ST_IDLE)
        |=> SYS_RESET && !WDT_IRQ;
  endproperty
  a_wdt: assert property (p_wdt) else $error("wdt reset missed");

  property p_restart;
    @(posedge CLK) disable iff (!RESET_N)
      $fell(SYS_RESET) |-> CPU_RESTART && CPU_CLK_DIV8;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");

  property p_supply_monitor_one_control_keep;
    @(posedge CLK) disable iff (!RESET_N)
      (fire && !cold) |=> supply_monitor_one_control_reg == $past(supply_monitor_one_control_reg);
  endproperty
  a_supply_monitor_one_control_keep: assert property (p_supply_monitor_one_control_keep) else $error("supply_monitor_one_control lost");

  property p_m1_gate;
    @(posedge CLK) disable iff (!RESET_N) !det1_reg |-> !m1_req;
  endproperty
  a_m1_gate: assert property (p_m1_gate) else $error("m1 ungated");

  property p_m1_hold;
    @(posedge CLK) disable iff (!RESET_N)
      (hold_m1_reg && SYS_RESET && filt_lvl[0]) |=> SYS_RESET;
  endproperty
  a_m1_hold: assert property (p_m1_hold) else $error("m1 released");

  property p_m2_irq;
    @(posedge CLK) disable iff (!RESET_N)
      (m2_evt && !supply_monitor_two_control_reg[smr_pkg::B_MODE]) |=> MON2_IRQ && !SYS_RESET;
  endproperty
  a_m2_irq: assert property (p_m2_irq) else $error("m2 irq wrong");

  property p_flag_set;
    @(posedge CLK) disable iff (!RESET_N)
      cross_evt |=> supply_monitor_two_control_reg[smr_pkg::B_FLAG];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_keep;
    @(posedge CLK) disable iff (!RESET_N)
      // A new event in the firing cycle may still set its flag
      (fire && !cold) |=> supply_monitor_two_control_reg[3:2] == ($past(supply_monitor_two_control_reg[3:2]) |
        {$past(WDT_UNDERFLOW), $past(cross_evt)}) &&
        supply_monitor_two_control_reg[7:4] == 4'h0;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flags lost");

  property p_level;
    @(posedge CLK) disable iff (!RESET_N) !settled |-> !level2;
  endproperty
  a_level: assert property (p_level) else $error("level early");

  property p_pm0_read;
    @(posedge CLK) disable iff (!RESET_N)
      (PSEL && !PENABLE && !PWRITE && hit(PADDR, smr_pkg::IDX_PM0))
        |=> PRDATA == 32'h0000_0000;
  endproperty
  a_pm0_read: assert property (p_pm0_read) else $error("pm0 nonzero");
endmodule : smr_top

/* verif/smr_top_tb_top.sv */
module smr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cmp1_below, cmp2_below, power_on_det, wdt_underflow;
  logic det1_enable, det2_enable, slow_osc_run, sys_reset, sfr_reset;
  logic cpu_restart, cpu_clk_div8, mon2_irq, wdt_irq;
  int miscompares = 0;
  int n_compared = 0;
  int n_irq = 0;
  int n_wdt = 0;
  int n_rst = 0;

  // Short counts keep soft, watchdog and monitor-2 reset sequences near 130 cycles
  smr_top #(.SETTLE_NS(400), .SLOW_DIV(4)) smr_top_inst (
    .CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CMP1_BELOW(cmp1_below),
    .CMP2_BELOW(cmp2_below), .POWER_ON_DET(power_on_det),
    .WDT_UNDERFLOW(wdt_underflow), .DET1_ENABLE(det1_enable),
    .DET2_ENABLE(det2_enable), .SLOW_OSC_RUN(slow_osc_run),
    .SYS_RESET(sys_reset), .SFR_RESET(sfr_reset),
    .CPU_RESTART(cpu_restart), .CPU_CLK_DIV8(cpu_clk_div8),
    .MON2_IRQ(mon2_irq), .WDT_IRQ(wdt_irq)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("Compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  always @(posedge clk) begin
    if (mon2_irq === 1'b1) n_irq <= n_irq + 1;
    if (wdt_irq === 1'b1) n_wdt <= n_wdt + 1;
    if (sfr_reset === 1'b1) n_rst <= n_rst + 1;
    if (cpu_restart === 1'b1) chk({31'h0, cpu_clk_div8}, 32'h0000_0001);
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Leading edge keeps a release and the next setup in separate steps
  task automatic apb(input logic wr_en, input logic [9:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic rdc(input logic [9:0] idx, input logic [7:0] mask,
                     input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd & {24'h00_0000, mask}, {24'h00_0000, exp});
  endtask : rdc

  task automatic wait_restart();
    int n;
    n = 0;
    while (cpu_restart !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, cpu_restart}, 32'h0000_0001);
    cyc(3);
  endtask : wait_restart

  task automatic pulse_wdt();
    wdt_underflow <= 1'b1;
    cyc(1);
    wdt_underflow <= 1'b0;
    cyc(4);
  endtask : pulse_wdt

  task automatic t_reset_vals();
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_ONE_CONTROL, 8'hFF, 8'h00);
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'hFF, 8'h00);
    rdc(smr_pkg::IDX_PM0, 8'hFF, 8'h00);
    apb(1'b0, 10'h3FF, 8'h00);
    chk({31'h0, err}, 32'h0000_0001);
    wr(smr_pkg::IDX_CM1, 8'h10);
    // Stop bit lands at the access edge; look one edge later
    cyc(1);
    chk({31'h0, slow_osc_run}, 32'h0000_0000);
    wr(smr_pkg::IDX_CM1, 8'h00);
    cyc(1);
    chk({31'h0, slow_osc_run}, 32'h0000_0001);
  endtask : t_reset_vals

  task automatic t_wdt();
    pulse_wdt();
    chk(n_wdt, 1);
    chk(n_rst, 0);
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'hFF, 8'h08);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'h08);
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'hFF, 8'h08);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'h00);
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'hFF, 8'h00);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_ONE_CONTROL, 8'h32);
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_ONE_CONTROL, 8'hFF, 8'h32);
    wr(smr_pkg::IDX_PM1, 8'h04);
    pulse_wdt();
    chk({31'h0, sys_reset}, 32'h0000_0001);
    wait_restart();
    chk(n_rst, 1);
    chk(n_wdt, 1);
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_ONE_CONTROL, 8'hFF, 8'h32);
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'hFF, 8'h08);
    rdc(smr_pkg::IDX_PM1, 8'hFF, 8'h00);
  endtask : t_wdt

  task automatic t_soft();
    wr(smr_pkg::IDX_PM0, 8'h08);
    cyc(2);
    chk({31'h0, sys_reset}, 32'h0000_0001);
    wait_restart();
    chk(n_rst, 2);
    rdc(smr_pkg::IDX_PM0, 8'hFF, 8'h00);
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'hFF, 8'h08);
  endtask : t_soft

  task automatic t_level();
    wr(smr_pkg::IDX_DETECT_CIRCUIT_CONTROL, 8'h80);
    cyc(20);
    chk({31'h0, det2_enable}, 32'h0000_0001);
    rdc(smr_pkg::IDX_DETECT_LEVEL_STATUS, 8'h08, 8'h08);
    // Sync plus four filter samples take about 20 cycles
    cmp2_below <= 1'b1;
    cyc(40);
    rdc(smr_pkg::IDX_DETECT_LEVEL_STATUS, 8'h08, 8'h00);
    cmp2_below <= 1'b0;
    cyc(40);
  endtask : t_level

  task automatic t_filter();
    int base;
    for (int d = 0; d < 4; d++) begin
      wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, {2'b00, d[1:0], 4'h0});
      cyc(20 << d);
      wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, {2'b00, d[1:0], 4'h1});
      base = n_irq;
      // Glitch spans at most two samples at this divider
      cmp2_below <= 1'b1;
      cyc(6 << d);
      cmp2_below <= 1'b0;
      cyc(60 << d);
      chk(n_irq, base);
      cmp2_below <= 1'b1;
      cyc(60 << d);
      chk(n_irq, base + 1);
      cmp2_below <= 1'b0;
      cyc(60 << d);
      chk(n_irq, base + 2);
    end
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'hFF, 8'h35);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'h35);
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'hFF, 8'h35);
  endtask : t_filter

  task automatic t_unfiltered();
    int base;
    wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'h82);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'h83);
    base = n_irq;
    cmp2_below <= 1'b1;
    cyc(12);
    chk(n_irq, base + 1);
    cmp2_below <= 1'b0;
    cyc(12);
    chk(n_irq, base + 1);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'h03);
    cmp2_below <= 1'b1;
    cyc(12);
    chk(n_irq, base + 1);
    cmp2_below <= 1'b0;
    cyc(12);
    chk(n_irq, base + 2);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'h00);
    wr(smr_pkg::IDX_DETECT_CIRCUIT_CONTROL, 8'h00);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'h03);
    cmp2_below <= 1'b1;
    cyc(12);
    cmp2_below <= 1'b0;
    cyc(12);
    chk(n_irq, base + 2);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'h00);
  endtask : t_unfiltered

  task automatic t_mon2_reset();
    int base;
    wr(smr_pkg::IDX_DETECT_CIRCUIT_CONTROL, 8'h80);
    cyc(20);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'hC2);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'hC3);
    base = n_rst;
    // Supply stays low: restart must not wait for recovery
    cmp2_below <= 1'b1;
    wait_restart();
    chk(n_rst, base + 1);
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_TWO_CONTROL, 8'hFF, 8'h04);
    chk({31'h0, det2_enable}, 32'h0000_0001);
    cmp2_below <= 1'b0;
    cyc(10);
  endtask : t_mon2_reset

  task automatic t_mon1();
    int base;
    base = n_rst;
    wr(smr_pkg::IDX_SUPPLY_MONITOR_ONE_CONTROL, 8'hC3);
    cmp1_below <= 1'b1;
    cyc(50);
    chk(n_rst, base);
    cmp1_below <= 1'b0;
    wr(smr_pkg::IDX_SUPPLY_MONITOR_ONE_CONTROL, 8'h00);
    wr(smr_pkg::IDX_DETECT_CIRCUIT_CONTROL, 8'hC0);
    cyc(20);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_ONE_CONTROL, 8'hC2);
    wr(smr_pkg::IDX_SUPPLY_MONITOR_ONE_CONTROL, 8'hC3);
    cmp1_below <= 1'b1;
    cyc(20);
    chk({31'h0, sys_reset}, 32'h0000_0001);
    cyc(400);
    chk({31'h0, sys_reset}, 32'h0000_0001);
    chk(n_rst, base + 1);
    cmp1_below <= 1'b0;
    wait_restart();
    rdc(smr_pkg::IDX_SUPPLY_MONITOR_ONE_CONTROL, 8'hFF, 8'h41);
    chk({31'h0, det1_enable}, 32'h0000_0001);
  endtask : t_mon1

  initial begin
    #(40 * 30000);
    miscompares++;
    results();
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cmp1_below = 1'b0;
    cmp2_below = 1'b0;
    power_on_det = 1'b0;
    wdt_underflow = 1'b0;
    cyc(12);
    reset_n <= 1'b1;
    cyc(6);
    t_reset_vals();
    t_wdt();
    t_soft();
    t_level();
    t_filter();
    t_unfiltered();
    t_mon2_reset();
    t_mon1();
    results();
  end
endmodule : smr_top_tb_top
